// ===== esc_pkg.sv
/*
  Constants for the Ethernet statistics counter block: register offsets,
  counter widths, frame length bin edges and reset values.
  Assumes an APB slave with 32-bit data and word-aligned registers.
*/
// Summary of operation
// (RQ1) Good transmitted frames add their length to the transmit byte counter.
// (RQ2) Exactly 64-byte clean frames, either direction, bump the minimum bin.
// (RQ3) A carrier-loss truncated transmit of 64 bytes still counts there.
// (RQ4) CRC, alignment, code errors and overruns never block 64 or 512-1023 bins.
// (RQ5) Clean frames of 65 to 127 bytes bump the small bin.
// (RQ6) Clean frames of 128 to 255 bytes bump the medium bin.
// (RQ7) Clean frames of 256 to 511 bytes bump the mid-large bin.
// (RQ8) Clean frames of 512 to 1023 bytes bump the large bin.
// (RQ9) Clean frames 1024 to maximum receive length bump the jumbo bin.
// (RQ10) Every frame of any size adds its bytes to the network byte counter.
// (RQ11) Bytes sent before carrier loss also count as network bytes.
// (RQ12) Bytes sent before each collision count again on every retry.
// (RQ13) Half-duplex received bytes count until jam; jam bytes are excluded.
// (RQ14) Errors, overruns and underruns never affect network byte counting.
// (RQ15) Accepted frames refused at start for lack of resources are counted.
// (RQ16) Accepted frames started but starved mid-frame are counted separately.
// (RQ17) Accepted frames hitting a zero head descriptor pointer count as DMA overruns.
// (RQ18) Overrun counters ignore CRC, alignment and code errors.
// (RQ19) Each frame credits at most one bin, by exactly one.
package esc_pkg;
  localparam int CNT_W = 32;
  localparam int LEN_W = 16;
  localparam int ADDR_W = 8;
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h00000000;
  localparam logic [LEN_W-1:0] MAXLEN_RESET = 16'h05EE;
  // Bin edges in bytes
  localparam logic [LEN_W-1:0] LEN_64 = 16'h0040;
  localparam logic [LEN_W-1:0] LEN_127 = 16'h007F;
  localparam logic [LEN_W-1:0] LEN_255 = 16'h00FF;
  localparam logic [LEN_W-1:0] LEN_511 = 16'h01FF;
  localparam logic [LEN_W-1:0] LEN_1023 = 16'h03FF;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_TX_GOOD_BYTES = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_BIN_EXACT_MIN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_BIN_SMALL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_BIN_MEDIUM = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_BIN_MID_LARGE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_BIN_LARGE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_BIN_JUMBO = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_NET_BYTES = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_RX_START_OVR = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_RX_MIDDLE_OVR = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_RX_DMA_OVR = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_MAX_RX_LEN = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h30;
  // Control register fields
  localparam int CTL_HALF_DUPLEX = 0;
  localparam int CTL_CLEAR_ALL = 1;
endpackage : esc_pkg

// ===== esc_stats.sv
/*
  Ethernet MAC statistics counters with an APB register slave.
  Assumes the MAC transmit and receive paths report each finished frame, each
  aborted attempt and each byte on the wire as one-cycle pulses on pclk.
*/
`timescale 1ns/1ps
module esc_stats
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit frame end report
  input wire logic tx_done,
  input wire logic [15:0] tx_len,
  input wire logic tx_late_coll,
  input wire logic tx_excess_coll,
  input wire logic tx_carrier_loss,
  input wire logic tx_underrun,
  // Receive frame end report
  input wire logic rx_done,
  input wire logic [15:0] rx_len,
  input wire logic rx_addr_match,
  // Byte activity on the wire
  input wire logic tx_byte,
  input wire logic tx_jam,
  input wire logic rx_byte,
  input wire logic rx_jam_sent,
  // Receive resource events
  input wire logic rx_start_overrun,
  input wire logic rx_middle_overrun,
  input wire logic rx_dma_head_zero,
  // Status
  output logic half_duplex
);

  logic [31:0] tx_good_byte_count_q;
  logic [31:0] bin_exact_min_frames_q;
  logic [31:0] bin_small_frames_q;
  logic [31:0] bin_medium_frames_q;
  logic [31:0] bin_mid_large_frames_q;
  logic [31:0] bin_large_frames_q;
  logic [31:0] bin_jumbo_frames_q;
  logic [31:0] network_byte_count_q;
  logic [31:0] rx_start_overrun_count_q;
  logic [31:0] rx_middle_overrun_count_q;
  logic [31:0] rx_dma_overrun_count_q;
  logic [15:0] max_receive_length_q;
  logic half_duplex_q;
  logic jam_block_q;
  logic clear_all;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  // Frame classification
  logic tx_clean;
  logic tx_bin_ok;
  logic [15:0] bin_len;
  logic bin_valid;
  logic [5:0] bin_hit;
  logic net_inc;
  logic rx_net_ok;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign half_duplex = half_duplex_q;
  assign clear_all = wr_en && (paddr == esc_pkg::OFS_CONTROL) && pwdata[esc_pkg::CTL_CLEAR_ALL];

  always_comb
  begin
    case (paddr)
      esc_pkg::OFS_TX_GOOD_BYTES, esc_pkg::OFS_BIN_EXACT_MIN, esc_pkg::OFS_BIN_SMALL,
      esc_pkg::OFS_BIN_MEDIUM, esc_pkg::OFS_BIN_MID_LARGE, esc_pkg::OFS_BIN_LARGE,
      esc_pkg::OFS_BIN_JUMBO, esc_pkg::OFS_NET_BYTES, esc_pkg::OFS_RX_START_OVR,
      esc_pkg::OFS_RX_MIDDLE_OVR, esc_pkg::OFS_RX_DMA_OVR, esc_pkg::OFS_MAX_RX_LEN,
      esc_pkg::OFS_CONTROL: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Unmapped addresses answer with an error in the same cycle
  assign pslverr = psel && penable && !addr_ok;

  // Carrier loss does not stop a truncated 64-byte transmit from binning
  assign tx_clean = !tx_late_coll && !tx_excess_coll && !tx_carrier_loss && !tx_underrun; // RQ1
  assign tx_bin_ok = !tx_late_coll && !tx_excess_coll && !tx_underrun
                     && (!tx_carrier_loss || tx_len == esc_pkg::LEN_64); // RQ2 RQ3

  // Transmit has priority on a shared bin cycle; receive is credited a cycle later
  logic rx_pend_q;
  logic [15:0] rx_pend_len_q;
  logic bin_from_rx;
  assign bin_from_rx = !(tx_done && tx_bin_ok);

  always_comb
  begin
    bin_len = 16'h0000;
    bin_valid = 1'b0;
    if (tx_done && tx_bin_ok)
    begin
      bin_len = tx_len;
      bin_valid = 1'b1;
    end
    else if (rx_pend_q)
    begin
      // Receive errors are not inputs here on purpose
      bin_len = rx_pend_len_q; // RQ4
      bin_valid = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_pend_q <= 1'b0;
      rx_pend_len_q <= 16'h0000;
    end
    else if (rx_done && rx_addr_match)
    begin
      rx_pend_q <= 1'b1;
      rx_pend_len_q <= rx_len;
    end
    else if (bin_from_rx)
    begin
      rx_pend_q <= 1'b0;
    end
  end

  // One-hot: each frame lands in at most one bin
  always_comb
  begin
    bin_hit = 6'h00;
    if (bin_valid) // RQ19
    begin
      if (bin_len == esc_pkg::LEN_64)
        bin_hit[0] = 1'b1; // RQ2
      else if (bin_len > esc_pkg::LEN_64 && bin_len <= esc_pkg::LEN_127)
        bin_hit[1] = 1'b1; // RQ5
      else if (bin_len > esc_pkg::LEN_127 && bin_len <= esc_pkg::LEN_255)
        bin_hit[2] = 1'b1; // RQ6
      else if (bin_len > esc_pkg::LEN_255 && bin_len <= esc_pkg::LEN_511)
        bin_hit[3] = 1'b1; // RQ7
      else if (bin_len > esc_pkg::LEN_511 && bin_len <= esc_pkg::LEN_1023)
        bin_hit[4] = 1'b1; // RQ8
      else if (bin_len > esc_pkg::LEN_1023 && bin_len <= max_receive_length_q)
        bin_hit[5] = 1'b1; // RQ9
    end
  end

  // Network bytes: every wire byte, jam excluded, receive stops after flow-control jam in half duplex
  assign rx_net_ok = rx_byte && !(half_duplex_q && jam_block_q); // RQ13
  assign net_inc = (tx_byte && !tx_jam) || rx_net_ok; // RQ10 RQ11 RQ12 RQ14

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      jam_block_q <= 1'b0;
    else if (rx_jam_sent)
      jam_block_q <= 1'b1; // RQ13
    else if (rx_done)
      jam_block_q <= 1'b0;
  end

  // Configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      max_receive_length_q <= esc_pkg::MAXLEN_RESET;
      half_duplex_q <= 1'b0;
    end
    else if (wr_en && paddr == esc_pkg::OFS_MAX_RX_LEN)
      max_receive_length_q <= pwdata[15:0];
    else if (wr_en && paddr == esc_pkg::OFS_CONTROL)
      half_duplex_q <= pwdata[esc_pkg::CTL_HALF_DUPLEX];
  end

  // Transmit good byte count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_good_byte_count_q <= esc_pkg::CNT_RESET;
    else if (tx_done && tx_clean)
      tx_good_byte_count_q <= tx_good_byte_count_q + {16'h0000, tx_len}; // RQ1
    else if (clear_all)
      tx_good_byte_count_q <= esc_pkg::CNT_RESET;
  end

  // Bin counters; an event in a clear cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bin_exact_min_frames_q <= esc_pkg::CNT_RESET;
      bin_small_frames_q <= esc_pkg::CNT_RESET;
      bin_medium_frames_q <= esc_pkg::CNT_RESET;
      bin_mid_large_frames_q <= esc_pkg::CNT_RESET;
      bin_large_frames_q <= esc_pkg::CNT_RESET;
      bin_jumbo_frames_q <= esc_pkg::CNT_RESET;
    end
    else
    begin
      if (bin_hit[0])
        bin_exact_min_frames_q <= bin_exact_min_frames_q + 32'h00000001; // RQ19
      else if (clear_all)
        bin_exact_min_frames_q <= esc_pkg::CNT_RESET;
      if (bin_hit[1])
        bin_small_frames_q <= bin_small_frames_q + 32'h00000001;
      else if (clear_all)
        bin_small_frames_q <= esc_pkg::CNT_RESET;
      if (bin_hit[2])
        bin_medium_frames_q <= bin_medium_frames_q + 32'h00000001;
      else if (clear_all)
        bin_medium_frames_q <= esc_pkg::CNT_RESET;
      if (bin_hit[3])
        bin_mid_large_frames_q <= bin_mid_large_frames_q + 32'h00000001;
      else if (clear_all)
        bin_mid_large_frames_q <= esc_pkg::CNT_RESET;
      if (bin_hit[4])
        bin_large_frames_q <= bin_large_frames_q + 32'h00000001;
      else if (clear_all)
        bin_large_frames_q <= esc_pkg::CNT_RESET;
      if (bin_hit[5])
        bin_jumbo_frames_q <= bin_jumbo_frames_q + 32'h00000001;
      else if (clear_all)
        bin_jumbo_frames_q <= esc_pkg::CNT_RESET;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      network_byte_count_q <= esc_pkg::CNT_RESET;
    else if (net_inc)
      network_byte_count_q <= network_byte_count_q + {31'h00000000, tx_byte && !tx_jam}
                              + {31'h00000000, rx_net_ok}; // RQ10
    else if (clear_all)
      network_byte_count_q <= esc_pkg::CNT_RESET;
  end

  // Overrun counters take only accepted frames; receive errors are not inputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_start_overrun_count_q <= esc_pkg::CNT_RESET;
      rx_middle_overrun_count_q <= esc_pkg::CNT_RESET;
      rx_dma_overrun_count_q <= esc_pkg::CNT_RESET;
    end
    else
    begin
      if (rx_start_overrun && rx_addr_match)
        rx_start_overrun_count_q <= rx_start_overrun_count_q + 32'h00000001; // RQ15 RQ18
      else if (clear_all)
        rx_start_overrun_count_q <= esc_pkg::CNT_RESET;
      if (rx_middle_overrun && rx_addr_match)
        rx_middle_overrun_count_q <= rx_middle_overrun_count_q + 32'h00000001; // RQ16
      else if (clear_all)
        rx_middle_overrun_count_q <= esc_pkg::CNT_RESET;
      if (rx_dma_head_zero && rx_addr_match)
        rx_dma_overrun_count_q <= rx_dma_overrun_count_q + 32'h00000001; // RQ17
      else if (clear_all)
        rx_dma_overrun_count_q <= esc_pkg::CNT_RESET;
    end
  end

  // Read data from flip-flops, taken at the edge ending the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        esc_pkg::OFS_TX_GOOD_BYTES: prdata <= tx_good_byte_count_q;
        esc_pkg::OFS_BIN_EXACT_MIN: prdata <= bin_exact_min_frames_q;
        esc_pkg::OFS_BIN_SMALL: prdata <= bin_small_frames_q;
        esc_pkg::OFS_BIN_MEDIUM: prdata <= bin_medium_frames_q;
        esc_pkg::OFS_BIN_MID_LARGE: prdata <= bin_mid_large_frames_q;
        esc_pkg::OFS_BIN_LARGE: prdata <= bin_large_frames_q;
        esc_pkg::OFS_BIN_JUMBO: prdata <= bin_jumbo_frames_q;
        esc_pkg::OFS_NET_BYTES: prdata <= network_byte_count_q;
        esc_pkg::OFS_RX_START_OVR: prdata <= rx_start_overrun_count_q;
        esc_pkg::OFS_RX_MIDDLE_OVR: prdata <= rx_middle_overrun_count_q;
        esc_pkg::OFS_RX_DMA_OVR: prdata <= rx_dma_overrun_count_q;
        esc_pkg::OFS_MAX_RX_LEN: prdata <= {16'h0000, max_receive_length_q};
        esc_pkg::OFS_CONTROL: prdata <= {31'h00000000, half_duplex_q};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // Byte counters
  a_tx_good_bytes: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    (tx_done && tx_clean) |=> tx_good_byte_count_q == $past(tx_good_byte_count_q) + {16'h0000, $past(tx_len)})
    else $error("good transmit bytes not added");
  a_tx_bad_no_bytes: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    (tx_done && !tx_clean && !clear_all) |=> $stable(tx_good_byte_count_q))
    else $error("faulty transmit counted");
  a_net_jam: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
    (tx_jam && !rx_byte && !clear_all) |=> $stable(network_byte_count_q))
    else $error("jam byte counted");
  a_net_rx_block: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
    (half_duplex_q && jam_block_q && rx_byte && !tx_byte && !clear_all) |=> $stable(network_byte_count_q))
    else $error("receive byte counted after flow-control jam");
  a_net_tx_byte: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    (tx_byte && !tx_jam && !rx_byte) |=> network_byte_count_q == $past(network_byte_count_q) + 32'h00000001)
    else $error("transmit byte not counted");
  a_net_both: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    (tx_byte && !tx_jam && rx_byte && !half_duplex_q)
    |=> network_byte_count_q == $past(network_byte_count_q) + 32'h00000002)
    else $error("simultaneous transmit and receive bytes not both counted");

  // Length bins
  a_bin_onehot: assert property (@(posedge pclk) disable iff (!presetn) $onehot0(bin_hit)) // RQ19
    else $error("frame credited to more than one bin");
  a_bin_idle: assert property (@(posedge pclk) disable iff (!presetn) // RQ19
    (!bin_valid && !clear_all) |=> $stable(bin_small_frames_q) && $stable(bin_jumbo_frames_q))
    else $error("bin moved without a frame");
  a_bin64_tx: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    (tx_done && tx_len == esc_pkg::LEN_64 && !tx_late_coll && !tx_excess_coll && !tx_underrun)
    |=> bin_exact_min_frames_q == $past(bin_exact_min_frames_q) + 32'h00000001)
    else $error("64-byte transmit not binned");
  a_bin64_rx: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    (rx_pend_q && !(tx_done && tx_bin_ok) && rx_pend_len_q == esc_pkg::LEN_64)
    |=> bin_exact_min_frames_q == $past(bin_exact_min_frames_q) + 32'h00000001)
    else $error("64-byte receive not binned");
  a_tx_carrier_bin: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    (tx_done && tx_carrier_loss && tx_len != esc_pkg::LEN_64 && !rx_pend_q && !clear_all)
    |=> $stable(bin_small_frames_q))
    else $error("carrier-loss transmit binned");
  a_bin_small_rx: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    (rx_pend_q && !tx_done && rx_pend_len_q > esc_pkg::LEN_64 && rx_pend_len_q <= esc_pkg::LEN_127)
    |=> bin_small_frames_q == $past(bin_small_frames_q) + 32'h00000001)
    else $error("small receive frame not binned");
  a_bin_medium_tx: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
    (tx_done && tx_clean && tx_len > esc_pkg::LEN_127 && tx_len <= esc_pkg::LEN_255)
    |=> bin_medium_frames_q == $past(bin_medium_frames_q) + 32'h00000001)
    else $error("medium transmit frame not binned");
  a_bin_mid_large_tx: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    (tx_done && tx_clean && tx_len > esc_pkg::LEN_255 && tx_len <= esc_pkg::LEN_511)
    |=> bin_mid_large_frames_q == $past(bin_mid_large_frames_q) + 32'h00000001)
    else $error("mid-large transmit frame not binned");
  a_bin_large_tx: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
    (tx_done && tx_clean && tx_len > esc_pkg::LEN_511 && tx_len <= esc_pkg::LEN_1023)
    |=> bin_large_frames_q == $past(bin_large_frames_q) + 32'h00000001)
    else $error("large transmit frame not binned");
  a_bin_jumbo_tx: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    (tx_done && tx_clean && tx_len > esc_pkg::LEN_1023 && tx_len <= max_receive_length_q)
    |=> bin_jumbo_frames_q == $past(bin_jumbo_frames_q) + 32'h00000001)
    else $error("jumbo transmit frame not binned");
  a_jumbo_limit: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    (bin_valid && bin_len > max_receive_length_q) |-> !bin_hit[5])
    else $error("oversize frame in jumbo bin");

  // Receive overruns
  a_start_ovr: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
    (rx_start_overrun && rx_addr_match) |=> rx_start_overrun_count_q == $past(rx_start_overrun_count_q) + 32'h00000001)
    else $error("start overrun missed");
  a_start_unmatched: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
    (rx_start_overrun && !rx_addr_match && !clear_all) |=> $stable(rx_start_overrun_count_q))
    else $error("unmatched start overrun counted");
  a_middle_ovr: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
    (rx_middle_overrun && rx_addr_match)
    |=> rx_middle_overrun_count_q == $past(rx_middle_overrun_count_q) + 32'h00000001)
    else $error("middle overrun missed");
  a_dma_ovr: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
    (rx_dma_head_zero && rx_addr_match) |=> rx_dma_overrun_count_q == $past(rx_dma_overrun_count_q) + 32'h00000001)
    else $error("dma overrun missed");
  a_dma_unmatched: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
    (rx_dma_head_zero && !rx_addr_match && !clear_all) |=> $stable(rx_dma_overrun_count_q))
    else $error("unmatched dma overrun counted");

endmodule : esc_stats

// ===== esc_phy_model.sv
/*
  Far-side model of the MAC paths: frame end reports, wire byte activity and
  receive resource events, each a one-cycle pulse launched after a rising edge.
  Assumes the bench calls one task at a time and passes its own random seed.
*/
`timescale 1ns/1ps
module esc_phy_model
(
  // Clock
  input wire logic pclk,
  // Transmit report
  output logic tx_done,
  output logic [15:0] tx_len,
  output logic tx_late_coll,
  output logic tx_excess_coll,
  output logic tx_carrier_loss,
  output logic tx_underrun,
  // Receive report
  output logic rx_done,
  output logic [15:0] rx_len,
  output logic rx_addr_match,
  // Wire bytes
  output logic tx_byte,
  output logic tx_jam,
  output logic rx_byte,
  output logic rx_jam_sent,
  // Resource events
  output logic rx_start_overrun,
  output logic rx_middle_overrun,
  output logic rx_dma_head_zero
);
  initial
  begin
    {tx_done, rx_done, tx_byte, tx_jam, rx_byte, rx_jam_sent} = 6'h00;
    {rx_start_overrun, rx_middle_overrun, rx_dma_head_zero} = 3'h0;
    {tx_late_coll, tx_excess_coll, tx_carrier_loss, tx_underrun} = 4'h0;
    tx_len = 16'h0000;
    rx_len = 16'h0000;
    rx_addr_match = 1'b0;
  end

  // Qualifiers show the inverse once the report is gone, so stale values never pass
  task tx_frame(input logic [15:0] len, input logic [3:0] f);
    @(posedge pclk);
    tx_done <= 1'b1;
    tx_len <= len;
    {tx_late_coll, tx_excess_coll, tx_carrier_loss, tx_underrun} <= f;
    @(posedge pclk);
    tx_done <= 1'b0;
    tx_len <= ~len;
    {tx_late_coll, tx_excess_coll, tx_carrier_loss, tx_underrun} <= ~f;
    repeat (3) @(posedge pclk);
  endtask : tx_frame

  // Three idle cycles keep receive reports well over two cycles apart
  task rx_event(input logic [15:0] len, input logic m, input logic d, input logic [2:0] k);
    @(posedge pclk);
    rx_done <= d;
    rx_len <= len;
    rx_addr_match <= m;
    {rx_start_overrun, rx_middle_overrun, rx_dma_head_zero} <= k;
    @(posedge pclk);
    rx_done <= 1'b0;
    rx_len <= ~len;
    rx_addr_match <= ~m;
    {rx_start_overrun, rx_middle_overrun, rx_dma_head_zero} <= 3'h0;
    repeat (3) @(posedge pclk);
  endtask : rx_event

  // Random byte traffic with a flow-control jam half way; a, b, c count tx, rx before, rx after
  task bytes(input int n, inout int s, output int a, output int b, output int c);
    int i;
    logic [2:0] v;
    a = 0;
    b = 0;
    c = 0;
    for (i = 0; i < n; i++)
    begin
      v = $random(s);
      @(posedge pclk);
      tx_byte <= v[0];
      tx_jam <= v[1];
      rx_jam_sent <= (i == n / 2);
      rx_byte <= v[2] && (i != n / 2);
      rx_addr_match <= v[1];
      a += v[0] && !v[1];
      if (v[2] && i < n / 2)
        b++;
      if (v[2] && i > n / 2)
        c++;
    end
    @(posedge pclk);
    {tx_byte, tx_jam, rx_byte, rx_jam_sent} <= 4'h0;
    rx_event(16'h0100, 1'b0, 1'b1, 3'h0);
  endtask : bytes
endmodule : esc_phy_model

// ===== tb_top.sv
/*
  Self-checking bench for the statistics counters: APB master, far-side model
  and an integer model of every register compared after each phase.
  Assumes the zero-wait APB slave and pulse reports described for the block.
*/
`timescale 1ns/1ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, half_duplex;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic tx_done, tx_late_coll, tx_excess_coll, tx_carrier_loss, tx_underrun, rx_done, rx_addr_match;
  logic tx_byte, tx_jam, rx_byte, rx_jam_sent, rx_start_overrun, rx_middle_overrun, rx_dma_head_zero;
  logic [15:0] tx_len, rx_len;
  logic e;
  int mismatches, compares, seed, i, a, b, c;
  int exp_c [0:12];
  int lens [0:12] = '{63, 64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024, 1518, 1519};
  logic [15:0] rv;

  esc_stats esc_stats_i (.*);
  esc_phy_model esc_phy_model_i (.*);

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task chk(input string n, input logic [31:0] seen, input logic [31:0] expv);
    compares++;
    if (seen !== expv)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, expv, seen);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      chk("pready", 32'h0, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task check_all;
    int k;
    for (k = 0; k < 13; k++)
    begin
      apb(1'b0, 8'(k * 4), 32'h0, r, e);
      chk($sformatf("reg%0d", k), r, 32'(exp_c[k]));
      chk("rd_err", {31'h0, e}, 32'h0);
    end
    chk("half_duplex", {31'h0, half_duplex}, 32'(exp_c[12]));
  endtask : check_all

  function int bin_of(int len);
    if (len == 64) return 1;
    if (len >= 65 && len <= 127) return 2;
    if (len >= 128 && len <= 255) return 3;
    if (len >= 256 && len <= 511) return 4;
    if (len >= 512 && len <= 1023) return 5;
    if (len >= 1024 && len <= exp_c[11]) return 6;
    return 0;
  endfunction : bin_of

  // Flags are {late, excessive, carrier loss, underrun}
  task do_tx(input int len, input logic [3:0] f);
    esc_phy_model_i.tx_frame(16'(len), f);
    if (f == 4'h0)
      exp_c[0] += len;
    if (!f[3] && !f[2] && !f[0] && (!f[1] || len == 64) && bin_of(len) > 0)
      exp_c[bin_of(len)]++;
  endtask : do_tx

  task do_rx(input int len, input logic m);
    esc_phy_model_i.rx_event(16'(len), m, 1'b1, 3'h0);
    if (m && bin_of(len) > 0)
      exp_c[bin_of(len)]++;
  endtask : do_rx

  task do_bytes;
    esc_phy_model_i.bytes(60, seed, a, b, c);
    exp_c[7] += a + b + (exp_c[12] ? 0 : c);
  endtask : do_bytes

  task print_verdict;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  initial
  begin
    #(100 * 40000);
    mismatches++;
    print_verdict;
  end

  initial
  begin
    seed = 32'hCF80CC3B;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    for (i = 0; i < 13; i++)
      exp_c[i] = 0;
    exp_c[11] = 32'h000005EE;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    check_all;
    apb(1'b1, 8'h40, 32'hFFFFFFFF, r, e);
    chk("wr_unmapped_err", {31'h0, e}, 32'h1);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("rd_unmapped_err", {31'h0, e}, 32'h1);
    chk("rd_unmapped_data", r, 32'h0);
    apb(1'b1, 8'h00, 32'h12345678, r, e);
    for (i = 0; i < 13; i++)
    begin
      do_tx(lens[i], 4'h0);
      do_tx(lens[i], 4'h2);
      do_tx(lens[i], 4'(1 << (i % 4)));
      do_rx(lens[i], 1'b1);
      do_rx(lens[i], 1'b0);
    end
    check_all;
    for (i = 0; i < 60; i++)
    begin
      if (i == 30)
      begin
        apb(1'b1, 8'h2C, 32'h0000044C, r, e);
        exp_c[11] = 32'h0000044C;
      end
      rv = $random(seed);
      do_tx((i < 30) ? rv[10:0] : 900 + rv[8:0], rv[15] ? rv[14:11] : 4'h0);
      rv = $random(seed);
      do_rx((i < 30) ? rv[10:0] : 900 + rv[8:0], rv[15]);
    end
    check_all;
    for (i = 0; i < 16; i++)
    begin
      esc_phy_model_i.rx_event(16'h0200, i[3], 1'b0, i[2:0]);
      exp_c[8] += i[3] && i[2];
      exp_c[9] += i[3] && i[1];
      exp_c[10] += i[3] && i[0];
    end
    do_bytes;
    check_all;
    apb(1'b1, 8'h30, 32'h00000001, r, e);
    exp_c[12] = 1;
    do_bytes;
    do_tx(64, 4'h2);
    check_all;
    apb(1'b1, 8'h30, 32'h00000003, r, e);
    for (i = 0; i < 11; i++)
      exp_c[i] = 0;
    check_all;
    print_verdict;
  end
endmodule : tb_top
